//--- csh_defines.svh
`ifndef CSH_DEFINES_SVH
`define CSH_DEFINES_SVH

// ----------------------------------------------------------------
// Buffer-memory word addresses
// ----------------------------------------------------------------
`define CSH_ADDR_ERRCODE   16'h0000
`define CSH_ADDR_STATUS    16'h018e
`define CSH_ADDR_COMMAND   16'h018f
`define CSH_ADDR_ALERT0    16'h0191
`define CSH_ALERT_STRIDE   16'h00c8

// ----------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------
`define CSH_ST_READY       0
`define CSH_ST_MODE        1
`define CSH_ST_ERROR       2
`define CSH_ST_HWERR       3
`define CSH_ST_TUNE0       4
`define CSH_ST_BKDONE      8
`define CSH_ST_DEFDONE     9
`define CSH_ST_BKFAIL      10
`define CSH_ST_CHGDONE     11
`define CSH_ST_ALERT0      12

// ----------------------------------------------------------------
// Command word bit positions, writable mask and reset values
// ----------------------------------------------------------------
`define CSH_CM_MODE        1
`define CSH_CM_ERRRST      2
`define CSH_CM_TUNE0       4
`define CSH_CM_BACKUP      8
`define CSH_CM_DEFAULT     9
`define CSH_CM_CHANGE      11
`define CSH_CMD_MASK       16'h0bf6
`define CSH_CMD_RESET      16'h0000
`define CSH_WORD_ZERO      16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CSH_STARTUP_MS     5000
`define CSH_CLK_KHZ        10000

`endif

//--- csh_pkg.sv
package csh_pkg;

    // Start-up sequencer, one-hot
    typedef enum logic [2:0] {
        CSH_INIT   = 3'b001,
        CSH_SETTLE = 3'b010,
        CSH_RUN    = 3'b100
    } csh_state_e;

    typedef logic [15:0] csh_word_t;

endpackage : csh_pkg

//--- csh_edge_det.sv
`timescale 1ns/1ps
module csh_edge_det
    import csh_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] prev_reg;

    // ------------------------------------------------------------
    // Per-bit edge detection
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // Previous value starts at zero, so a bit that is high out of
            // reset reads as a rise until the first clock after reset
            always_ff @(posedge mclk) begin
                if (reset) begin
                    prev_reg[i] <= 1'b0;
                end else begin
                    prev_reg[i] <= level[i];
                end
            end
            assign rise[i] = level[i] & ~prev_reg[i];
            assign fall[i] = ~level[i] & prev_reg[i];
        end
    endgenerate

endmodule : csh_edge_det

//--- csh_command_status.sv
//
// Functional notes
// - Ready bit set after initialization completes
// - No control for five seconds after power-up
// - Mode status high in operation mode
// - Store error code before raising error bit
// - Hardware failure sets hardware error bit
// - Tuning bit high while tuning, self-clears
// - Backup on rise; done set, cleared on fall
// - Default restore on rise; done when written
// - Failed backup sets backup failure bit
// - Apply settings on rise; done, cleared on fall
// - Write alert detail, then set summary bit
// - Error reset rise clears error state
// - Tuning command rise starts tuning, raises status
// - Default command fall clears done bit
// - Accept accesses only while ready
`timescale 1ns/1ps
`include "csh_defines.svh"
module csh_command_status
    import csh_pkg::*;
#(
    parameter int unsigned STARTUP_CYCLES = `CSH_STARTUP_MS * `CSH_CLK_KHZ,
    parameter int          CHANNELS       = 4
) (
    input  wire logic                     mclk,
    input  wire logic                     reset,
    input  wire logic                     initDone,
    input  wire logic                     hwFault,
    input  wire logic                     errValid,
    input  wire logic [15:0]              errCode,
    input  wire logic [CHANNELS-1:0]      tuneDone,
    input  wire logic                     backupDone,
    input  wire logic                     backupFail,
    input  wire logic                     defaultDone,
    input  wire logic                     applyDone,
    input  wire logic [CHANNELS-1:0]      alertValid,
    input  wire logic [16*CHANNELS-1:0]   alertDetail,
    input  wire logic                     bmReq,
    input  wire logic                     bmWrite,
    input  wire logic [15:0]              bmAddr,
    input  wire logic [15:0]              bmWdata,
    output logic      [15:0]              bmRdata,
    output logic                          bmAck,
    output logic                          moduleReady,
    output logic                          opMode,
    output logic                          controlEnable,
    output logic      [CHANNELS-1:0]      tuneStart,
    output logic                          backupStart,
    output logic                          defaultStart,
    output logic                          applyStart,
    output logic                          errReset
);

    localparam int CW = $clog2(STARTUP_CYCLES + 1);

    // ------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------
    csh_state_e    state_reg;
    csh_state_e    state_next;
    logic [CW-1:0] settle_reg;
    logic          settleDone;

    assign settleDone = (settle_reg == CW'(STARTUP_CYCLES - 1));

    // Ready waits for both init and the settling delay
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CSH_INIT:   if (initDone) state_next = CSH_SETTLE;
            CSH_SETTLE: if (settleDone) state_next = CSH_RUN;
            CSH_RUN:    state_next = CSH_RUN;
            default:    state_next = CSH_INIT;
        endcase
    end

    // Settling counter only runs in the settle state
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg  <= CSH_INIT;
            settle_reg <= '0;
        end else begin
            state_reg  <= state_next;
            if (state_reg == CSH_SETTLE && !settleDone) begin
                settle_reg <= settle_reg + CW'(1);
            end
        end
    end

    assign moduleReady = (state_reg == CSH_RUN);

    // ------------------------------------------------------------
    // Buffer-memory access decode
    // ------------------------------------------------------------
    csh_word_t command_reg;
    logic      acc;
    logic      cmdWr;

    assign acc   = bmReq & moduleReady;
    assign bmAck = acc;
    assign cmdWr = acc & bmWrite & (bmAddr == `CSH_ADDR_COMMAND);

    // Only documented command bits are stored
    always_ff @(posedge mclk) begin
        if (reset) begin
            command_reg <= `CSH_CMD_RESET;
        end else if (cmdWr) begin
            command_reg <= bmWdata & `CSH_CMD_MASK;
        end
    end

    // ------------------------------------------------------------
    // Command edges
    // ------------------------------------------------------------
    csh_word_t cmdRise;
    csh_word_t cmdFall;

    csh_edge_det #(.WIDTH(16)) u_edges (
        .mclk  (mclk),
        .reset (reset),
        .level (command_reg),
        .rise  (cmdRise),
        .fall  (cmdFall)
    );

    // Mode follows the command bit; control held off until ready
    assign opMode        = command_reg[`CSH_CM_MODE];
    assign controlEnable = moduleReady & opMode;

    // Start pulses registered one cycle after the edge
    always_ff @(posedge mclk) begin
        if (reset) begin
            tuneStart    <= '0;
            backupStart  <= 1'b0;
            defaultStart <= 1'b0;
            applyStart   <= 1'b0;
            errReset     <= 1'b0;
        end else begin
            tuneStart    <= cmdRise[`CSH_CM_TUNE0 +: CHANNELS];
            backupStart  <= cmdRise[`CSH_CM_BACKUP];
            defaultStart <= cmdRise[`CSH_CM_DEFAULT];
            applyStart   <= cmdRise[`CSH_CM_CHANGE];
            errReset     <= cmdRise[`CSH_CM_ERRRST];
        end
    end

    // ------------------------------------------------------------
    // Error code and error flags
    // ------------------------------------------------------------
    csh_word_t errCode_reg;
    logic      errPend_reg;
    logic      error_reg;
    logic      hwErr_reg;

    // Code lands first, flag a cycle later; a new error beats a reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            errCode_reg <= `CSH_WORD_ZERO;
            errPend_reg <= 1'b0;
            error_reg   <= 1'b0;
            hwErr_reg   <= 1'b0;
        end else begin
            errPend_reg <= errValid;
            if (errValid) begin
                errCode_reg <= errCode;
            end else if (cmdRise[`CSH_CM_ERRRST]) begin
                errCode_reg <= `CSH_WORD_ZERO;
            end
            if (errPend_reg) begin
                error_reg <= 1'b1;
            end else if (cmdRise[`CSH_CM_ERRRST]) begin
                error_reg <= 1'b0;
            end
            if (hwFault) begin
                hwErr_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Handshake completion flags (set wins over clear)
    // ------------------------------------------------------------
    logic [CHANNELS-1:0] tune_reg;
    logic                bkDone_reg;
    logic                bkFail_reg;
    logic                defDone_reg;
    logic                chgDone_reg;

    always_ff @(posedge mclk) begin
        if (reset) begin
            tune_reg    <= '0;
            bkDone_reg  <= 1'b0;
            bkFail_reg  <= 1'b0;
            defDone_reg <= 1'b0;
            chgDone_reg <= 1'b0;
        end else begin
            tune_reg <= cmdRise[`CSH_CM_TUNE0 +: CHANNELS]
                      | (tune_reg & ~tuneDone);
            if (backupDone) begin
                bkDone_reg <= 1'b1;
            end else if (cmdFall[`CSH_CM_BACKUP]) begin
                bkDone_reg <= 1'b0;
            end
            // Failure stays until the next backup begins
            if (backupFail) begin
                bkFail_reg <= 1'b1;
            end else if (cmdRise[`CSH_CM_BACKUP]) begin
                bkFail_reg <= 1'b0;
            end
            if (defaultDone) begin
                defDone_reg <= 1'b1;
            end else if (cmdFall[`CSH_CM_DEFAULT]) begin
                defDone_reg <= 1'b0;
            end
            if (applyDone) begin
                chgDone_reg <= 1'b1;
            end else if (cmdFall[`CSH_CM_CHANGE]) begin
                chgDone_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Per-channel alert detail and summary
    // ------------------------------------------------------------
    logic [15:0]         alertWord_reg [CHANNELS];
    logic [CHANNELS-1:0] alertSum_reg;
    logic [CHANNELS-1:0] alertHit;

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_alert
            // Summary follows the stored word one cycle later, so
            // the detail is always readable before the flag shows
            always_ff @(posedge mclk) begin
                if (reset) begin
                    alertWord_reg[c] <= `CSH_WORD_ZERO;
                    alertSum_reg[c]  <= 1'b0;
                end else begin
                    if (alertValid[c]) begin
                        alertWord_reg[c] <= alertDetail[16*c +: 16];
                    end
                    alertSum_reg[c] <= |alertWord_reg[c];
                end
            end
            assign alertHit[c] = (bmAddr == 16'(`CSH_ADDR_ALERT0
                                 + c * `CSH_ALERT_STRIDE));
        end
    endgenerate

    // ------------------------------------------------------------
    // Status word and read mux
    // ------------------------------------------------------------
    csh_word_t statusWord;
    csh_word_t alertRead;
    csh_word_t readWord;

    always_comb begin
        statusWord = `CSH_WORD_ZERO;
        statusWord[`CSH_ST_READY]   = moduleReady;
        statusWord[`CSH_ST_MODE]    = opMode;
        statusWord[`CSH_ST_ERROR]   = error_reg;
        statusWord[`CSH_ST_HWERR]   = hwErr_reg;
        statusWord[`CSH_ST_TUNE0 +: CHANNELS]  = tune_reg;
        statusWord[`CSH_ST_BKDONE]  = bkDone_reg;
        statusWord[`CSH_ST_DEFDONE] = defDone_reg;
        statusWord[`CSH_ST_BKFAIL]  = bkFail_reg;
        statusWord[`CSH_ST_CHGDONE] = chgDone_reg;
        statusWord[`CSH_ST_ALERT0 +: CHANNELS] = alertSum_reg;
        alertRead = `CSH_WORD_ZERO;
        for (int k = 0; k < CHANNELS; k++) begin
            if (alertHit[k]) begin
                alertRead = alertWord_reg[k];
            end
        end
    end

    // Unmapped addresses read as zero
    assign readWord = (bmAddr == `CSH_ADDR_STATUS)  ? statusWord  :
                      (bmAddr == `CSH_ADDR_COMMAND) ? command_reg :
                      (bmAddr == `CSH_ADDR_ERRCODE) ? errCode_reg :
                      alertRead;

    // Read data registered; holds until the next accepted read
    always_ff @(posedge mclk) begin
        if (reset) begin
            bmRdata <= `CSH_WORD_ZERO;
        end else if (acc && !bmWrite) begin
            bmRdata <= readWord;
        end
    end

endmodule : csh_command_status

//--- csh_command_status_chk.sv
`timescale 1ns/1ps
`include "csh_defines.svh"
module csh_command_status_chk
    import csh_pkg::*;
#(
    parameter int unsigned STARTUP_CYCLES = 20,
    parameter int          CHANNELS       = 4
) (
    input wire logic                   mclk,
    input wire logic                   reset,
    input wire logic                   initDone,
    input wire logic                   hwFault,
    input wire logic                   errValid,
    input wire logic [15:0]            errCode,
    input wire logic [CHANNELS-1:0]    tuneDone,
    input wire logic                   backupDone,
    input wire logic                   backupFail,
    input wire logic                   defaultDone,
    input wire logic                   applyDone,
    input wire logic [CHANNELS-1:0]    alertValid,
    input wire logic [16*CHANNELS-1:0] alertDetail,
    input wire logic                   bmReq,
    input wire logic                   bmWrite,
    input wire logic [15:0]            bmAddr,
    input wire logic [15:0]            bmWdata,
    input wire logic [15:0]            bmRdata,
    input wire logic                   bmAck,
    input wire logic                   moduleReady,
    input wire logic                   opMode,
    input wire logic                   controlEnable,
    input wire logic [CHANNELS-1:0]    tuneStart,
    input wire logic                   backupStart,
    input wire logic                   defaultStart,
    input wire logic                   applyStart,
    input wire logic                   errReset
);
    // ------------------------------------------------------------
    // Shadow of the command word and start-up wait counter
    // ------------------------------------------------------------
    // Acceptance uses ready, not ack, so a bad ack cannot hide itself
    logic        cmdWr;
    logic        cmdRd;
    csh_word_t   cmdRise;
    csh_word_t   cmd_reg;
    csh_word_t   cmd_next;
    int unsigned wait_reg;
    int unsigned wait_next;
    assign cmdWr = bmReq && moduleReady && bmWrite
                   && bmAddr == `CSH_ADDR_COMMAND;
    assign cmdRd = bmReq && moduleReady && !bmWrite
                   && bmAddr == `CSH_ADDR_COMMAND;
    assign cmdRise = cmdWr ? bmWdata & `CSH_CMD_MASK & ~cmd_reg : '0;
    assign cmd_next = cmdWr ? bmWdata & `CSH_CMD_MASK : cmd_reg;
    assign wait_next = (initDone && !moduleReady) ? wait_reg + 1 : wait_reg;
    always_ff @(posedge mclk) begin
        cmd_reg <= reset ? `CSH_CMD_RESET : cmd_next;
        wait_reg <= reset ? 0 : wait_next;
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    a_ack_ready_gate: assert property (
        bmAck == (bmReq && moduleReady))
        else $error("Ack does not follow request and ready");
    a_control_gate: assert property (
        controlEnable == (moduleReady && opMode))
        else $error("Control enable not gated by ready and mode");
    a_ready_cause: assert property (
        $rose(moduleReady) |-> initDone)
        else $error("Ready rose without init done");
    a_ready_settle: assert property (
        $rose(moduleReady) |-> wait_reg >= STARTUP_CYCLES
                               && wait_reg <= STARTUP_CYCLES + 2)
        else $error("Ready rose outside the settle time");
    a_backup_start: assert property (
        cmdRise[`CSH_CM_BACKUP] |-> ##2 backupStart)
        else $error("Backup rise gave no start pulse");
    a_default_start: assert property (
        cmdRise[`CSH_CM_DEFAULT] |-> ##2 defaultStart)
        else $error("Default rise gave no start pulse");
    a_apply_start: assert property (
        cmdRise[`CSH_CM_CHANGE] |-> ##2 applyStart)
        else $error("Change rise gave no start pulse");
    a_errrst_pulse: assert property (
        cmdRise[`CSH_CM_ERRRST] |-> ##2 errReset)
        else $error("Error reset rise gave no pulse");
    a_tune_start: assert property (
        |cmdRise[7:4] |-> ##2 tuneStart == $past(cmdRise[7:4], 2))
        else $error("Tuning start does not match command rise");
    a_start_cause: assert property (
        backupStart |-> $past(cmdRise[`CSH_CM_BACKUP], 2))
        else $error("Backup start without command rise");
    a_cmd_readback: assert property (
        cmdRd |=> bmRdata == $past(cmd_reg))
        else $error("Command readback differs from masked writes");
    c_backup: cover property (backupStart);
    c_apply: cover property (applyStart);
    c_errrst: cover property (errReset);
    c_ready: cover property ($rose(moduleReady));
endmodule : csh_command_status_chk

bind csh_command_status csh_command_status_chk #(
    .STARTUP_CYCLES(STARTUP_CYCLES), .CHANNELS(CHANNELS)
) u_chk (
    .mclk(mclk), .reset(reset), .initDone(initDone), .hwFault(hwFault),
    .errValid(errValid), .errCode(errCode), .tuneDone(tuneDone),
    .backupDone(backupDone), .backupFail(backupFail),
    .defaultDone(defaultDone), .applyDone(applyDone),
    .alertValid(alertValid), .alertDetail(alertDetail), .bmReq(bmReq),
    .bmWrite(bmWrite), .bmAddr(bmAddr), .bmWdata(bmWdata),
    .bmRdata(bmRdata), .bmAck(bmAck), .moduleReady(moduleReady),
    .opMode(opMode), .controlEnable(controlEnable), .tuneStart(tuneStart),
    .backupStart(backupStart), .defaultStart(defaultStart),
    .applyStart(applyStart), .errReset(errReset)
);

//--- csh_engine_model.sv
`timescale 1ns/1ps
module csh_engine_model (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       slow,
    input  wire logic       failNext,
    input  wire logic [3:0] tuneStart,
    input  wire logic       backupStart,
    input  wire logic       defaultStart,
    input  wire logic       applyStart,
    output logic      [3:0] tuneDone,
    output logic            backupDone,
    output logic            backupFail,
    output logic            defaultDone,
    output logic            applyDone
);
    // ------------------------------------------------------------
    // Engines: each start comes back as a one-cycle completion
    // ------------------------------------------------------------
    // A shared delay line keeps the model tiny; slow picks the far tap
    logic [3:0][6:0] stage_reg;
    logic [6:0]      doneVec;
    logic            bkDone;
    always_ff @(posedge mclk) begin
        if (reset) stage_reg <= '0;
        else stage_reg <= {stage_reg[2:0],
                           {applyStart, defaultStart, backupStart, tuneStart}};
    end
    assign doneVec = slow ? stage_reg[3] : stage_reg[0];
    assign {applyDone, defaultDone, bkDone, tuneDone} = doneVec;
    assign backupDone = bkDone && !failNext;
    assign backupFail = bkDone && failNext; // Storage refused the write
endmodule : csh_engine_model

//--- csh_command_status_bench.sv
`timescale 1ns/1ps
`include "csh_defines.svh"
module csh_command_status_bench import csh_pkg::*;;
    logic        mclk, reset, initDone, hwFault, errValid, bmReq, bmWrite;
    logic        backupDone, backupFail, defaultDone, applyDone, bmAck;
    logic        moduleReady, opMode, controlEnable, backupStart;
    logic        defaultStart, applyStart, errReset, failNext, slow, rdPend;
    logic [3:0]  tuneDone, alertValid, tuneStart;
    logic [15:0] errCode, bmAddr, bmWdata, bmRdata;
    logic [63:0] alertDetail;
    csh_word_t   expQ[$];
    csh_word_t   st, rnd, sticky;
    int          err_total, checked, cyc;
    int          bitTab[5] = '{8, 8, 9, 11, 8};
    integer      seed;

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    csh_command_status #(.STARTUP_CYCLES(20), .CHANNELS(4)) dut (
        .mclk(mclk), .reset(reset), .initDone(initDone), .hwFault(hwFault),
        .errValid(errValid), .errCode(errCode), .tuneDone(tuneDone),
        .backupDone(backupDone), .backupFail(backupFail),
        .defaultDone(defaultDone), .applyDone(applyDone),
        .alertValid(alertValid), .alertDetail(alertDetail), .bmReq(bmReq),
        .bmWrite(bmWrite), .bmAddr(bmAddr), .bmWdata(bmWdata),
        .bmRdata(bmRdata), .bmAck(bmAck), .moduleReady(moduleReady),
        .opMode(opMode), .controlEnable(controlEnable),
        .tuneStart(tuneStart), .backupStart(backupStart),
        .defaultStart(defaultStart), .applyStart(applyStart),
        .errReset(errReset));

    csh_engine_model engines (
        .mclk(mclk), .reset(reset), .slow(slow), .failNext(failNext),
        .tuneStart(tuneStart), .backupStart(backupStart),
        .defaultStart(defaultStart), .applyStart(applyStart),
        .tuneDone(tuneDone), .backupDone(backupDone),
        .backupFail(backupFail), .defaultDone(defaultDone),
        .applyDone(applyDone));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input csh_word_t got, input csh_word_t exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One bus access; for a read, d is the expected word
    task automatic acc(input logic w, input csh_word_t a, input csh_word_t d);
        @(posedge mclk);
        bmReq <= 1'b1;
        bmWrite <= w;
        bmAddr <= a;
        bmWdata <= d;
        if (!w) expQ.push_back(d);
        @(posedge mclk);
        bmReq <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : acc

    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    // Read data stands one cycle after the taking edge
    always @(posedge mclk) begin
        if (rdPend) chk(bmRdata, expQ.pop_front());
        rdPend <= bmReq && bmAck && !bmWrite;
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h2cce5904;
        reset = 1'b1;
        {initDone, hwFault, errValid, bmReq, bmWrite, failNext, slow} = '0;
        {errCode, bmAddr, bmWdata, alertValid, alertDetail} = '0;
        {rdPend, err_total, checked, cyc} = '0;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        acc(1'b1, `CSH_ADDR_COMMAND, 16'h0002);
        initDone <= 1'b1;
        for (int i = 0; i < 100 && !moduleReady; i++) @(posedge mclk);
        acc(1'b0, `CSH_ADDR_COMMAND, 16'h0000);
        acc(1'b0, `CSH_ADDR_STATUS, 16'h0001);
        acc(1'b1, `CSH_ADDR_COMMAND, 16'hf409);
        acc(1'b1, 16'h0190, 16'hffff);
        acc(1'b0, `CSH_ADDR_COMMAND, 16'h0000);
        acc(1'b1, `CSH_ADDR_COMMAND, 16'h0002);
        acc(1'b0, `CSH_ADDR_STATUS, 16'h0003);
        chk({14'h0, opMode, controlEnable}, 16'h0003);
        acc(1'b1, `CSH_ADDR_COMMAND, 16'h0000);
        chk({14'h0, opMode, controlEnable}, 16'h0000);
        // Backup, failed backup, default, change, then a clean backup
        for (int i = 0; i < 5; i++) begin
            sticky = (i >= 1 && i <= 3) ? 16'h0400 : 16'h0000;
            failNext <= (i == 1);
            slow <= 1'($random(seed));
            acc(1'b1, `CSH_ADDR_COMMAND, 16'(1 << bitTab[i]));
            repeat (8) @(posedge mclk);
            rnd = (i == 1) ? 16'h0000 : 16'(1 << bitTab[i]);
            acc(1'b0, `CSH_ADDR_STATUS, 16'h0001 | sticky | rnd);
            acc(1'b1, `CSH_ADDR_COMMAND, 16'h0000);
            acc(1'b0, `CSH_ADDR_STATUS, 16'h0001 | sticky);
        end
        // Tuning per channel; the slow engine keeps the bit visible
        slow <= 1'b1;
        for (int ch = 0; ch < 4; ch++) begin
            acc(1'b1, `CSH_ADDR_COMMAND, 16'(16'h0010 << ch));
            acc(1'b0, `CSH_ADDR_STATUS, 16'(16'h0010 << ch) | 16'h0001);
            repeat (8) @(posedge mclk);
            acc(1'b0, `CSH_ADDR_STATUS, 16'h0001);
            acc(1'b1, `CSH_ADDR_COMMAND, 16'h0000);
        end
        rnd = 16'($random(seed)) | 16'h0001;
        errCode <= rnd;
        errValid <= 1'b1;
        @(posedge mclk);
        errValid <= 1'b0;
        acc(1'b0, `CSH_ADDR_ERRCODE, rnd);
        acc(1'b0, `CSH_ADDR_STATUS, 16'h0005);
        acc(1'b1, `CSH_ADDR_COMMAND, 16'h0004);
        acc(1'b0, `CSH_ADDR_ERRCODE, 16'h0000);
        acc(1'b0, `CSH_ADDR_STATUS, 16'h0001);
        acc(1'b1, `CSH_ADDR_COMMAND, 16'h0000);
        st = 16'h0001;
        for (int ch = 0; ch < 4; ch++) begin
            rnd = 16'($random(seed)) | 16'h0100;
            alertDetail[16*ch +: 16] <= rnd;
            alertValid <= 4'(1 << ch);
            @(posedge mclk);
            alertValid <= 4'h0;
            acc(1'b0, 16'(`CSH_ADDR_ALERT0 + ch * `CSH_ALERT_STRIDE), rnd);
            st = st | 16'(16'h1000 << ch);
            acc(1'b0, `CSH_ADDR_STATUS, st);
        end
        hwFault <= 1'b1;
        acc(1'b0, `CSH_ADDR_STATUS, st | 16'h0008);
        repeat (2) @(posedge mclk);
        end_sim();
    end
endmodule : csh_command_status_bench
